// File: hw/dow_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the option word decoder
// Assumes: 200 MHz core clock
// Notes:   Definitions only
`ifndef DOW_MAP_SVH
`define DOW_MAP_SVH
// ****************************************
// Address map
// ****************************************
`define DOW_CFG_SPACE_LO 16'h2000
`define DOW_CFG_SPACE_HI 16'h3FFF
`define DOW_OPTION_ADDR 16'h2007
// ****************************************
// Field positions of the option word
// ****************************************
`define DOW_OSC_LSB 0
`define DOW_OSC_MSB 2
`define DOW_WDOG_BIT 3
`define DOW_PUD_DIS_BIT 4
`define DOW_RSTPIN_BIT 5
`define DOW_LOCK_BIT 6
`define DOW_IFREQ_BIT 7
`define DOW_BOR_LSB 8
`define DOW_BOR_MSB 9
// Unprogrammed bits read as one
`define DOW_OPTION_RST 16'hFFFF
// ****************************************
// Timing
// ****************************************
`define DOW_CLK_MHZ 200
`define DOW_PUD_MS 64
`define DOW_PUD_CYC (`DOW_PUD_MS * 1000 * `DOW_CLK_MHZ)
`define DOW_OST_CYC 1024
`endif

// File: hw/dow_pkg.sv
// Purpose: Types of the option word decoder
// Assumes: Field codes of the oscillator select and codes of the decoder states
// Notes:   Constants live in dow_map.svh
package dow_pkg;
    typedef enum logic [2:0] {
        DOW_OSC_LOW_POWER_CRYSTAL = 3'h0,
        DOW_OSC_STANDARD_CRYSTAL = 3'h1,
        DOW_OSC_FAST_CRYSTAL = 3'h2,
        DOW_OSC_DRIVEN_CLOCK = 3'h3,
        DOW_OSC_INTERNAL_PINS_FREE = 3'h4,
        DOW_OSC_INTERNAL_CLOCK_OUT = 3'h5,
        DOW_OSC_RC_PINS_FREE = 3'h6,
        DOW_OSC_RC_CLOCK_OUT = 3'h7
    } dow_osc_t;
    typedef enum logic [2:0] {
        DOW_ST_PUD = 3'h0,
        DOW_ST_OST = 3'h1,
        DOW_ST_RUN = 3'h2,
        DOW_ST_BOR = 3'h3,
        DOW_ST_SLEEP = 3'h4
    } dow_state_t;
endpackage : dow_pkg

// File: hw/dow_hold_timer.sv
// Purpose: Down counter that holds reset for a programmable count
// Assumes: Start restarts the count at any time
// Notes:   Done is high once the count ran out
`timescale 1ns/1ps
module dow_hold_timer #(
    parameter int WIDTH = 24
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    input wire logic start_i,
    input wire logic [WIDTH-1:0] load_i,
    output logic done_o
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic busy;
    } dow_tmr_t;
    dow_tmr_t st_r;
    dow_tmr_t st_nxt;
    // ****************************************
    // Count
    // ****************************************
    // Reload on start, so a repeated brown-out restarts the full wait
    always_comb begin
        st_nxt = st_r;
        if (start_i) begin
            st_nxt.cnt = load_i;
            st_nxt.busy = 1'b1;
        end else if (st_r.busy) begin
            if (st_r.cnt <= WIDTH'(1)) begin
                st_nxt.busy = 1'b0;
            end
            st_nxt.cnt = st_r.cnt - WIDTH'(1);
        end
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            st_r <= '0;
        end else if (CE_I) begin
            st_r <= st_nxt;
        end
    end
    assign done_o = ~st_r.busy & ~start_i;
endmodule : dow_hold_timer

// File: hw/dow_option_decode.sv
// Purpose: Option word decode, power-up and brown-out reset hold, sleep wake sources
// Assumes: Option word arrives from configuration memory; SYS_RST_I is the power-on pulse
// Notes:   Settings are captured once after reset and held while running
//
// Contract
// - Power-up holds reset for 64 ms
// - Start-up timer waits for stable crystal
// - Brown-out resets, optionally holding 64 ms
// - Sleep wakes on reset, watchdog, interrupt
// - Programmed bit reads 0, unprogrammed 1
// - Option word lives at 2007h
// - Configuration space reachable only while programming
// - Unlocking code erases all program memory
// - Bit 5 selects reset pin or input
// - Bit 4 one disables power-up timer
// - Bit 3 one enables watchdog
// - Oscillator codes for RC and internal
// - Oscillator codes for clock input, crystals
// - Brown-out enable leaves power-up timer alone
// - Reset pin stops internal or RC oscillator
// - Brown-out mode 10 off during sleep
`timescale 1ns/1ps
`include "dow_map.svh"
module dow_option_decode
    import dow_pkg::*;
#(
    parameter int PUD_CYC = `DOW_PUD_CYC,
    parameter int OST_CYC = `DOW_OST_CYC,
    parameter int TW = 24
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    input wire logic PROG_MODE_I,
    input wire logic [15:0] PROG_ADDR_I,
    input wire logic [15:0] PROG_WDATA_I,
    input wire logic PROG_WR_I,
    input wire logic PROG_BULK_ERASE_I,
    input wire logic RESET_PIN_N_I,
    input wire logic BROWNOUT_I,
    input wire logic SLEEP_REQ_I,
    input wire logic WDOG_WAKE_I,
    input wire logic IRQ_WAKE_I,
    output logic [15:0] PROG_RDATA_O,
    output logic [2:0] OSC_MODE_O,
    output logic CLOCK_OUT_EN_O,
    output logic OSC_PIN1_IO_O,
    output logic OSC_PIN2_IO_O,
    output logic OSC_RUN_O,
    output logic WDOG_EN_O,
    output logic FAST_INT_OSC_O,
    output logic CODE_LOCK_O,
    output logic PROG_MEM_ERASE_O,
    output logic BROWNOUT_DET_EN_O,
    output logic CORE_RESET_O,
    output logic SLEEPING_O,
    output logic [2:0] WAKE_SRC_O
);
    typedef struct packed {
        logic [15:0] word;
        logic [15:0] held;
        logic captured;
        dow_state_t state;
        logic erase;
        logic [2:0] wake;
        logic [1:0] pin_s;
        logic [1:0] bo_s;
    } dow_st_t;
    dow_st_t st_r;
    dow_st_t st_nxt;
    logic pud_start;
    logic pud_done;
    logic ost_start;
    logic ost_done;
    logic pud_off;
    logic osc_crystal;
    logic pin_reset;
    logic bo_on;
    logic in_cfg;
    dow_osc_t osc;
    // ****************************************
    // Held decode
    // ****************************************
    assign osc = dow_osc_t'(st_r.held[`DOW_OSC_MSB:`DOW_OSC_LSB]);
    assign pud_off = st_r.held[`DOW_PUD_DIS_BIT];
    assign osc_crystal = (osc == DOW_OSC_LOW_POWER_CRYSTAL) || (osc == DOW_OSC_STANDARD_CRYSTAL)
        || (osc == DOW_OSC_FAST_CRYSTAL);
    // Pin only counts as reset when its function bit selects it
    assign pin_reset = st_r.held[`DOW_RSTPIN_BIT] & ~st_r.pin_s[1];
    // Mode 11 always, 10 only while awake, 0x never
    assign bo_on = st_r.held[`DOW_BOR_MSB]
        & (st_r.held[`DOW_BOR_LSB] | (st_r.state != DOW_ST_SLEEP));
    assign in_cfg = (PROG_ADDR_I >= `DOW_CFG_SPACE_LO) && (PROG_ADDR_I <= `DOW_CFG_SPACE_HI);
    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        pud_start = 1'b0;
        ost_start = 1'b0;
        st_nxt.erase = 1'b0;
        // Pins come from outside, two flops first
        st_nxt.pin_s = {st_r.pin_s[0], RESET_PIN_N_I};
        st_nxt.bo_s = {st_r.bo_s[0], BROWNOUT_I};
        // Writes only reach the word while programming
        if (PROG_MODE_I && PROG_WR_I && (PROG_ADDR_I == `DOW_OPTION_ADDR)) begin
            st_nxt.word = PROG_WDATA_I;
            // Clearing the lock erases memory first
            if (!st_r.word[`DOW_LOCK_BIT] && PROG_WDATA_I[`DOW_LOCK_BIT]) begin
                st_nxt.erase = 1'b1;
            end
        end
        if (PROG_MODE_I && PROG_BULK_ERASE_I) begin
            st_nxt.word = `DOW_OPTION_RST;
            st_nxt.erase = 1'b1;
        end
        // Capture once, on the first edge after reset
        if (!st_r.captured) begin
            st_nxt.held = st_r.word;
            st_nxt.captured = 1'b1;
            pud_start = ~st_r.word[`DOW_PUD_DIS_BIT];
        end
        case (st_r.state)
            DOW_ST_PUD: begin
                if (st_r.captured && pud_done) begin
                    ost_start = osc_crystal;
                    st_nxt.state = DOW_ST_OST;
                end
            end
            DOW_ST_OST: begin
                if (ost_done && !ost_start) begin
                    st_nxt.state = DOW_ST_RUN;
                end
            end
            DOW_ST_RUN: begin
                if (SLEEP_REQ_I) begin
                    st_nxt.state = DOW_ST_SLEEP;
                    st_nxt.wake = 3'h0;
                end
            end
            DOW_ST_SLEEP: begin
                if (pin_reset || WDOG_WAKE_I || IRQ_WAKE_I) begin
                    st_nxt.wake = {IRQ_WAKE_I, WDOG_WAKE_I, pin_reset};
                    st_nxt.state = DOW_ST_RUN;
                end
            end
            DOW_ST_BOR: begin
                // Wait for supply back, then the optional hold
                if (!st_r.bo_s[1]) begin
                    pud_start = ~pud_off;
                    st_nxt.state = DOW_ST_PUD;
                end
            end
            default: begin
                st_nxt.state = DOW_ST_PUD;
            end
        endcase
        // Brown-out wins over everything, restarting the hold
        if (st_r.captured && bo_on && st_r.bo_s[1]) begin
            st_nxt.state = DOW_ST_BOR;
            pud_start = 1'b0;
            ost_start = 1'b0;
        end
    end
    // Option word is nonvolatile: reset keeps it, and a programmer may still write it then
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            st_r.word <= st_nxt.word;
            st_r.held <= `DOW_OPTION_RST;
            st_r.captured <= 1'b0;
            st_r.state <= DOW_ST_PUD;
            st_r.erase <= 1'b0;
            st_r.wake <= 3'h0;
            st_r.pin_s <= 2'h3;
            st_r.bo_s <= 2'h0;
        end else if (CE_I) begin
            st_r <= st_nxt;
        end
    end
    // ****************************************
    // Timers
    // ****************************************
    dow_hold_timer #(.WIDTH(TW)) u_pud (
        .CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .CE_I(CE_I),
        .start_i(pud_start),
        .load_i(TW'(PUD_CYC)),
        .done_o(pud_done)
    );
    dow_hold_timer #(.WIDTH(TW)) u_ost (
        .CLK_I(CLK_I),
        .SYS_RST_I(SYS_RST_I),
        .CE_I(CE_I),
        .start_i(ost_start),
        .load_i(TW'(OST_CYC)),
        .done_o(ost_done)
    );
    // ****************************************
    // Outputs
    // ****************************************
    // Read data outside config space or outside programming reads zero
    assign PROG_RDATA_O = (PROG_MODE_I && in_cfg && PROG_ADDR_I == `DOW_OPTION_ADDR)
        ? st_r.word : 16'h0000;
    assign OSC_MODE_O = st_r.held[`DOW_OSC_MSB:`DOW_OSC_LSB];
    assign CLOCK_OUT_EN_O = (osc == DOW_OSC_RC_CLOCK_OUT) || (osc == DOW_OSC_INTERNAL_CLOCK_OUT);
    assign OSC_PIN1_IO_O = (osc == DOW_OSC_INTERNAL_CLOCK_OUT)
        || (osc == DOW_OSC_INTERNAL_PINS_FREE);
    assign OSC_PIN2_IO_O = (osc == DOW_OSC_RC_PINS_FREE) || (osc == DOW_OSC_INTERNAL_PINS_FREE)
        || (osc == DOW_OSC_DRIVEN_CLOCK);
    // Internal and RC oscillators stop while reset pin is held
    assign OSC_RUN_O = ~(osc[2] & pin_reset);
    assign WDOG_EN_O = st_r.held[`DOW_WDOG_BIT];
    assign FAST_INT_OSC_O = st_r.held[`DOW_IFREQ_BIT];
    assign CODE_LOCK_O = ~st_r.held[`DOW_LOCK_BIT];
    assign PROG_MEM_ERASE_O = st_r.erase;
    assign BROWNOUT_DET_EN_O = bo_on;
    assign CORE_RESET_O = (st_r.state == DOW_ST_PUD) || (st_r.state == DOW_ST_OST)
        || (st_r.state == DOW_ST_BOR) || pin_reset || PROG_MODE_I;
    assign SLEEPING_O = (st_r.state == DOW_ST_SLEEP);
    assign WAKE_SRC_O = st_r.wake;
endmodule : dow_option_decode

// File: test/dow_option_props.sv
// Purpose: Port checks of the option word decoder
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the decoder below the module
`timescale 1ns/1ps
module dow_option_props (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PROG_MODE_I,
    input wire logic [15:0] PROG_ADDR_I,
    input wire logic [15:0] PROG_WDATA_I,
    input wire logic PROG_WR_I,
    input wire logic PROG_BULK_ERASE_I,
    input wire logic BROWNOUT_I,
    input wire logic [15:0] PROG_RDATA_O,
    input wire logic [2:0] OSC_MODE_O,
    input wire logic CLOCK_OUT_EN_O,
    input wire logic OSC_PIN2_IO_O,
    input wire logic OSC_RUN_O,
    input wire logic WDOG_EN_O,
    input wire logic CODE_LOCK_O,
    input wire logic PROG_MEM_ERASE_O,
    input wire logic BROWNOUT_DET_EN_O,
    input wire logic CORE_RESET_O,
    input wire logic SLEEPING_O,
    input wire logic [2:0] WAKE_SRC_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    // ****************************************
    // Programming port
    // ****************************************
    sequence s_opt_wr;
        PROG_MODE_I && PROG_WR_I && PROG_ADDR_I == 16'h2007;
    endsequence
    sequence s_opt_rd;
        PROG_MODE_I && PROG_ADDR_I == 16'h2007;
    endsequence
    a_read_back_word: assert property (
        s_opt_wr ##1 s_opt_rd |-> PROG_RDATA_O == $past(PROG_WDATA_I))
        else $error("Read back differs from write");
    a_other_addr_zero: assert property (
        PROG_MODE_I && PROG_ADDR_I != 16'h2007 |-> PROG_RDATA_O == 16'h0000)
        else $error("Other address not zero");
    a_closed_read_zero: assert property (!PROG_MODE_I |-> PROG_RDATA_O == 16'h0000)
        else $error("Read outside session");
    a_session_holds_core: assert property (PROG_MODE_I |-> CORE_RESET_O)
        else $error("Core runs while programming");
    // Decode follows the held field; crystals never stop
    a_clock_output_pin_decode: assert property (
        CLOCK_OUT_EN_O == (OSC_MODE_O == 3'h7 || OSC_MODE_O == 3'h5))
        else $error("Clock output decode");
    a_pin2_decode: assert property (
        OSC_PIN2_IO_O == (OSC_MODE_O == 3'h6 || OSC_MODE_O == 3'h4 || OSC_MODE_O == 3'h3))
        else $error("Second pin decode");
    a_crystal_runs: assert property (!OSC_MODE_O[2] |-> OSC_RUN_O)
        else $error("Crystal oscillator stopped");
    a_settings_held: assert property (
        !SYS_RST_I && !$past(SYS_RST_I) && !$past(SYS_RST_I, 2)
        |-> $stable(OSC_MODE_O) && $stable(WDOG_EN_O) && $stable(CODE_LOCK_O))
        else $error("Settings changed while running");
    a_brownout_resets: assert property (
        (BROWNOUT_I && BROWNOUT_DET_EN_O) [*5] |-> CORE_RESET_O)
        else $error("Brown-out did not reset");
    a_erase_one_pulse: assert property (
        PROG_MEM_ERASE_O |-> ($past(PROG_WR_I) || $past(PROG_BULK_ERASE_I)) ##1 !PROG_MEM_ERASE_O)
        else $error("Erase pulse without cause");
    a_wake_has_source: assert property (
        $fell(SLEEPING_O) |-> ##[0:1] WAKE_SRC_O != 3'h0)
        else $error("Wake without source");
endmodule : dow_option_props
bind dow_option_decode dow_option_props dow_option_props_i (.CLK_I, .SYS_RST_I,
    .PROG_MODE_I, .PROG_ADDR_I, .PROG_WDATA_I, .PROG_WR_I, .PROG_BULK_ERASE_I, .BROWNOUT_I,
    .PROG_RDATA_O, .OSC_MODE_O, .CLOCK_OUT_EN_O, .OSC_PIN2_IO_O, .OSC_RUN_O, .WDOG_EN_O,
    .CODE_LOCK_O, .PROG_MEM_ERASE_O, .BROWNOUT_DET_EN_O, .CORE_RESET_O, .SLEEPING_O,
    .WAKE_SRC_O);

// File: test/dow_prog_model.sv
// Purpose: Programmer model on the configuration port
// Assumes: Requests launched just after a rising edge
// Notes:   Idle data shows the inverse of the last word
`timescale 1ns/1ps
module dow_prog_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic mode_o = 1'b0,
    output logic [15:0] addr_o = 16'h0000,
    output logic [15:0] wdata_o = 16'h0000,
    output logic wr_o = 1'b0,
    output logic erase_o = 1'b0
);
    // Configuration space is reached only inside a session
    task automatic session(input logic on);
        @(posedge clk_i) mode_o <= on;
    endtask : session
    // One-cycle write or bulk erase strobe
    task automatic put(input logic [15:0] a, input logic [15:0] d, input logic bulk);
        @(posedge clk_i) begin
            addr_o <= a;
            wdata_o <= d;
            wr_o <= !bulk;
            erase_o <= bulk;
        end
        @(posedge clk_i) begin
            wr_o <= 1'b0;
            erase_o <= 1'b0;
            wdata_o <= ~d; // Stale data must never look valid
        end
    endtask : put
    task automatic get(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_i) addr_o <= a;
        // Data taken at the edge that ends the read cycle
        @(posedge clk_i) d = rdata_i;
    endtask : get
endmodule : dow_prog_model

// File: test/device_option_word_decode_tb_top.sv
// Purpose: Self-checking bench of the option word decoder
// Assumes: Short hold counts of 20 and 8 cycles
// Notes:   Sweeps all oscillator codes with mixed options
`timescale 1ns/1ps
module device_option_word_decode_tb_top;
    localparam int PUD = 20;
    localparam int OSC_STARTUP_TIMER = 8;
    logic CLK_I = 1'b0;
    logic SYS_RST_I = 1'b1;
    logic CE_I = 1'b1;
    logic RESET_PIN_N_I = 1'b1;
    logic BROWNOUT_I = 1'b0;
    logic SLEEP_REQ_I = 1'b0;
    logic WDOG_WAKE_I = 1'b0;
    logic IRQ_WAKE_I = 1'b0;
    logic PROG_MODE_I, PROG_WR_I, PROG_BULK_ERASE_I, OSC_RUN_O, CORE_RESET_O, SLEEPING_O;
    logic [15:0] PROG_ADDR_I, PROG_WDATA_I, PROG_RDATA_O, w, rd, x, y;
    logic [2:0] OSC_MODE_O, WAKE_SRC_O, osc, src;
    logic CLOCK_OUT_EN_O, OSC_PIN1_IO_O, OSC_PIN2_IO_O, WDOG_EN_O, FAST_INT_OSC_O;
    logic CODE_LOCK_O, PROG_MEM_ERASE_O, BROWNOUT_DET_EN_O;
    int miscompares = 0;
    int n_compared = 0;
    int erases = 0;
    int e, e0;
    always #2.5 CLK_I = ~CLK_I;
    // Erase pulses counted off the active edge
    always @(negedge CLK_I) if (PROG_MEM_ERASE_O === 1'b1) erases++;
    dow_option_decode #(.PUD_CYC(PUD), .OST_CYC(OSC_STARTUP_TIMER)) dow_option_decode_i (.CLK_I, .SYS_RST_I,
        .CE_I, .PROG_MODE_I, .PROG_ADDR_I, .PROG_WDATA_I, .PROG_WR_I, .PROG_BULK_ERASE_I,
        .RESET_PIN_N_I, .BROWNOUT_I, .SLEEP_REQ_I, .WDOG_WAKE_I, .IRQ_WAKE_I, .PROG_RDATA_O,
        .OSC_MODE_O, .CLOCK_OUT_EN_O, .OSC_PIN1_IO_O, .OSC_PIN2_IO_O, .OSC_RUN_O, .WDOG_EN_O,
        .FAST_INT_OSC_O, .CODE_LOCK_O, .PROG_MEM_ERASE_O, .BROWNOUT_DET_EN_O, .CORE_RESET_O,
        .SLEEPING_O, .WAKE_SRC_O);
    dow_prog_model dow_prog_model_i (.clk_i(CLK_I), .rdata_i(PROG_RDATA_O),
        .mode_o(PROG_MODE_I), .addr_o(PROG_ADDR_I), .wdata_o(PROG_WDATA_I), .wr_o(PROG_WR_I),
        .erase_o(PROG_BULK_ERASE_I));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask : tick
    task automatic hold_reset();
        @(posedge CLK_I) SYS_RST_I <= 1'b1;
        repeat (8) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
    endtask : hold_reset
    // Bounded wait for core release; length checked when e is known
    task automatic wait_run(input int e);
        int n;
        n = 0;
        while (CORE_RESET_O !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        if (n == 200) begin
            miscompares++;
            summarize();
        end else if (e >= 0) begin
            check(16'(n >= e && n <= e + 5), 16'h0001);
        end
    endtask : wait_run
    // Hang guard
    initial begin
        repeat (20000) @(posedge CLK_I);
        miscompares++;
        summarize();
    end
    initial begin
        // Blank part: erase the word while reset still holds the core
        fork
            hold_reset();
            begin
                dow_prog_model_i.session(1'b1);
                dow_prog_model_i.put(16'h2007, 16'h0000, 1'b1);
                dow_prog_model_i.session(1'b0);
            end
        join
        wait_run(0);
        dow_prog_model_i.session(1'b1);
        dow_prog_model_i.put(16'h2007, 16'h0000, 1'b1);
        dow_prog_model_i.get(16'h2007, rd);
        check(rd, 16'hFFFF);
        for (int i = 0; i < 8; i++) begin
            osc = i[2:0];
            w = {6'h3F, ~i[0], i[2], ~i[0], i[2], i != 7, i[1], i[0], osc};
            e = (i[1] ? 0 : PUD) + (i < 3 ? OSC_STARTUP_TIMER : 0);
            e0 = erases;
            dow_prog_model_i.session(1'b1);
            dow_prog_model_i.put(16'h2007, w & 16'hFFBF, 1'b0);
            dow_prog_model_i.put(16'h2007, w, 1'b0);
            dow_prog_model_i.get(16'h2007, rd);
            check(rd, w);
            check(16'(erases - e0), 16'(i[2]));
            dow_prog_model_i.get(16'h2006, rd);
            check(rd, 16'h0000);
            dow_prog_model_i.session(1'b0);
            dow_prog_model_i.get(16'h2007, rd);
            check(rd, 16'h0000);
            hold_reset();
            wait_run(e);
            x = {5'h00, osc, osc[2] & osc[0], osc[2:1] == 2'h2, osc == 6 || osc == 4 || osc == 3,
                 w[3], w[7], ~w[6], w[9], 1'b1};
            y = {5'h00, OSC_MODE_O, CLOCK_OUT_EN_O, OSC_PIN1_IO_O, OSC_PIN2_IO_O, WDOG_EN_O,
                 FAST_INT_OSC_O, CODE_LOCK_O, BROWNOUT_DET_EN_O, OSC_RUN_O};
            check(y, x);
            // Brown-out honours the power-up timer enable of bit 4, then the crystal start-up wait
            if (w[9]) begin
                @(posedge CLK_I) BROWNOUT_I <= 1'b1;
                tick(6);
                check(16'(CORE_RESET_O), 16'h0001);
                @(posedge CLK_I) BROWNOUT_I <= 1'b0;
                wait_run(e);
            end
            @(posedge CLK_I) SLEEP_REQ_I <= 1'b1;
            @(posedge CLK_I) SLEEP_REQ_I <= 1'b0;
            tick(2);
            check({12'h000, SLEEPING_O, WAKE_SRC_O}, 16'h0008);
            check(16'(BROWNOUT_DET_EN_O), 16'(w[9] & w[8]));
            src = 3'h4 >> (i % 3);
            @(posedge CLK_I) begin
                IRQ_WAKE_I <= src[2];
                WDOG_WAKE_I <= src[1];
                RESET_PIN_N_I <= !src[0];
            end
            tick(4);
            check(16'({CORE_RESET_O, OSC_RUN_O}), 16'({src[0], !(src[0] & osc[2])}));
            @(posedge CLK_I) begin
                IRQ_WAKE_I <= 1'b0;
                WDOG_WAKE_I <= 1'b0;
                RESET_PIN_N_I <= 1'b1;
            end
            wait_run(-1);
            check({12'h000, SLEEPING_O, WAKE_SRC_O}, {13'h0000, src});
            // Pin as plain input: no reset, oscillator keeps running
            if (i == 7) begin
                @(posedge CLK_I) RESET_PIN_N_I <= 1'b0;
                tick(4);
                check({14'h0, CORE_RESET_O, OSC_RUN_O}, 16'h0001);
                @(posedge CLK_I) RESET_PIN_N_I <= 1'b1;
            end
        end
        summarize();
    end
endmodule : device_option_word_decode_tb_top
